// >>> include/rcw_cfg.svh
`ifndef RCW_CFG_SVH
`define RCW_CFG_SVH

`define RCW_ADDR_CTRL    8'hB6
`define RCW_ADDR_REFRESH 8'hB7
`define RCW_ADDR_TIME_ACCESS_KEY   8'hF7

`define RCW_CTRL_RESET   8'h04
`define RCW_BIT_FLAG     7
`define RCW_BIT_EN       5
`define RCW_SEL_MSB      3
`define RCW_SEL_LSB      0
`define RCW_SEL_RESET    4'h4

`define RCW_REFRESH_KEY  8'h55
`define RCW_KEY_1        8'h55
`define RCW_KEY_2        8'hAA
`define RCW_KEY_3        8'h5A

`define RCW_CLK_KHZ      100000
`define RCW_RC_KHZ       250
`define RCW_RC_CYC       ((`RCW_CLK_KHZ) / (`RCW_RC_KHZ))
`define RCW_DIV_W        15
`define RCW_CNT_W        8
`define RCW_SETTLE       2'h3

`endif

// >>> include/rcw_pkg.sv
package rcw_pkg;

  typedef enum logic [3:0] {
    RCW_SEQ0 = 4'b0001,
    RCW_SEQ1 = 4'b0010,
    RCW_SEQ2 = 4'b0100,
    RCW_OPEN = 4'b1000
  } rcw_key_e;

  typedef struct packed {
    logic        flag;
    logic        en;
    logic [3:0]  sel;
    rcw_key_e    key;
    logic        opt_s1;
    logic        opt_s2;
    logic        opt_lat;
    logic [1:0]  settle;
    logic [14:0] divcnt;
    logic [7:0]  wcnt;
    logic [7:0]  rdata;
    logic        rst_req;
    logic        running;
  } rcw_state_s;

endpackage

// >>> hdl/rcw_tick_gen.sv
`timescale 1ns/1ns
`include "rcw_cfg.svh"
// stands in for the free-running RC oscillator: one tick per RC period,
// never cleared by software, so refresh cannot stretch the time base
module rcw_tick_gen #(
  parameter int CYC = `RCW_RC_CYC
) (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  output logic      tick_o
);
  localparam int W = $clog2(CYC);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } rcw_tick_s;

  rcw_tick_s st;
  rcw_tick_s next_st;

  if (CYC < 2) begin : g_bad_cyc
    $error("rcw_tick_gen: CYC must be at least 2");
  end

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == W'(CYC - 1)) begin
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + W'(1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;
endmodule

// >>> hdl/rcw_watchdog.sv
`timescale 1ns/1ns
`include "rcw_cfg.svh"
module rcw_watchdog
  import rcw_pkg::*;
#(
  parameter int RC_CYC = `RCW_RC_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       option_disable_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            mcu_reset_req_o,
  output logic            watchdog_running_o
);
  rcw_state_s st;
  rcw_state_s next_st;
  logic       rc_tick;
  logic       div_tick;
  logic       overflow;
  logic       wr_ctrl;
  logic       wr_refresh;
  logic       wr_key;
  logic [14:0] div_mask;

  if (RC_CYC < 2) begin : g_bad_rc_cyc
    $error("rcw_watchdog: RC_CYC must be at least 2");
  end

  rcw_tick_gen #(
    .CYC (RC_CYC)
  ) u_tick (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .tick_o    (rc_tick)
  );

  assign wr_ctrl    = sfr_wr_i && (sfr_addr_i == `RCW_ADDR_CTRL);
  assign wr_refresh = sfr_wr_i && (sfr_addr_i == `RCW_ADDR_REFRESH);
  assign wr_key     = sfr_wr_i && (sfr_addr_i == `RCW_ADDR_TIME_ACCESS_KEY);

  // divide by two to the select: fire when the low sel bits are all ones
  assign div_mask = 15'((16'h0001 << st.sel) - 16'h0001);
  assign div_tick = rc_tick && ((st.divcnt & div_mask) == div_mask);
  assign overflow = st.running && div_tick && (st.wcnt == 8'hFF);

  always_comb begin
    next_st = st;
    next_st.rst_req = 1'b0;
    next_st.rdata   = 8'h00;

    // option pin synchroniser; only the second stage is looked at.
    // both stages are cleared by reset, so the last copy, on the third
    // edge, is the first that really carries the pin
    next_st.opt_s1 = option_disable_i;
    next_st.opt_s2 = st.opt_s1;
    if (st.settle != `RCW_SETTLE) begin
      next_st.settle  = st.settle + 2'h1;
      next_st.opt_lat = st.opt_s2;
    end

    // time base keeps dividing while running; mclk never stops here, so
    // sleep does not pause it (the real part needs the RC domain for that)
    if (st.running) begin
      if (rc_tick) begin
        next_st.divcnt = st.divcnt + 15'h0001;
      end
      if (div_tick) begin
        next_st.wcnt = st.wcnt + 8'h01;
      end
    end

    // refresh: only the key value restarts the count
    if (wr_refresh && (sfr_wdata_i == `RCW_REFRESH_KEY)) begin
      next_st.wcnt   = 8'h00;
      next_st.divcnt = 15'h0000;
    end

    // unlock sequence; a wrong byte starts over, a 55h counts as first only from SEQ0 or OPEN
    if (wr_key) begin
      case (st.key)
        RCW_SEQ1: begin
          next_st.key = (sfr_wdata_i == `RCW_KEY_2) ? RCW_SEQ2 : RCW_SEQ0;
        end
        RCW_SEQ2: begin
          next_st.key = (sfr_wdata_i == `RCW_KEY_3) ? RCW_OPEN : RCW_SEQ0;
        end
        default: begin
          next_st.key = (sfr_wdata_i == `RCW_KEY_1) ? RCW_SEQ1 : RCW_SEQ0;
        end
      endcase
    end

    // control write only while open, and it relocks at once
    if (wr_ctrl && (st.key == RCW_OPEN)) begin
      next_st.key = RCW_SEQ0;
      next_st.sel = sfr_wdata_i[`RCW_SEL_MSB:`RCW_SEL_LSB];
      if (sfr_wdata_i[`RCW_BIT_EN]) begin
        next_st.en = 1'b1;
      end else if (!st.running) begin
        next_st.en = 1'b0;
      end
      if (!sfr_wdata_i[`RCW_BIT_FLAG]) begin
        next_st.flag = 1'b0;
      end
    end

    if (sfr_rd_i && (sfr_addr_i == `RCW_ADDR_CTRL)) begin
      next_st.rdata = {st.flag, 1'b0, st.en, 1'b0, st.sel};
    end

    // overflow acts as a chip reset for this block: set beats clear
    if (overflow) begin
      next_st.flag    = 1'b1;
      next_st.rst_req = 1'b1;
      next_st.en      = 1'b0;
      next_st.sel     = `RCW_SEL_RESET;
      next_st.key     = RCW_SEQ0;
      next_st.wcnt    = 8'h00;
      next_st.divcnt  = 15'h0000;
      next_st.settle  = 2'h0;
    end

    next_st.running = next_st.en && !next_st.opt_lat &&
                      (next_st.settle == `RCW_SETTLE);
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st         <= '0;
      st.flag    <= 1'b0;
      st.en      <= 1'b0;
      st.sel     <= `RCW_SEL_RESET;
      st.key     <= RCW_SEQ0;
      st.opt_lat <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign sfr_rdata_o        = st.rdata;
  assign mcu_reset_req_o    = st.rst_req;
  assign watchdog_running_o = st.running;
endmodule

// >>> sim/rcw_watchdog_monitor.sv
`timescale 1ns/1ns
module rcw_mon #(parameter int RC_CYC = 400) (
  input logic       mclk_i,
  input logic       sys_rst_i,
  input logic [7:0] sfr_addr_i,
  input logic       sfr_wr_i,
  input logic       sfr_rd_i,
  input logic [7:0] sfr_wdata_i,
  input logic       option_disable_i,
  input logic [7:0] sfr_rdata_o,
  input logic       mcu_reset_req_o,
  input logic       watchdog_running_o
);
  logic en_wr;
  assign en_wr = sfr_wr_i && sfr_addr_i == 8'hB6 && sfr_wdata_i[5];
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_ref;
    watchdog_running_o && sfr_wr_i && sfr_addr_i == 8'hB7 && sfr_wdata_i == 8'h55;
  endsequence
  property p_rst; $fell(sys_rst_i) |-> !watchdog_running_o; endproperty
  a_rst: assert property (p_rst) else $error("run at reset");
  property p_pls; mcu_reset_req_o |=> !mcu_reset_req_o; endproperty
  a_pls: assert property (p_pls) else $error("long pulse");
  property p_clr; mcu_reset_req_o |=> !watchdog_running_o; endproperty
  a_clr: assert property (p_clr) else $error("enable kept");
  // running drops on the same edge that raises the request
  property p_src; mcu_reset_req_o |-> $past(watchdog_running_o); endproperty
  a_src: assert property (p_src) else $error("reset while idle");
  property p_stay; watchdog_running_o |=> watchdog_running_o || mcu_reset_req_o; endproperty
  a_stay: assert property (p_stay) else $error("stopped");
  property p_run; $rose(watchdog_running_o) |-> $past(en_wr) || $past(en_wr, 2); endproperty
  a_run: assert property (p_run) else $error("start w/o write");
  property p_rd0; !sfr_rd_i |=> sfr_rdata_o == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("stale data");
  // refresh must push overflow well away, not merely land on it
  property p_ref; s_ref |=> !mcu_reset_req_o [*8]; endproperty
  a_ref: assert property (p_ref) else $error("reset after refresh");
endmodule
bind rcw_watchdog rcw_mon #(.RC_CYC(RC_CYC)) mon_u (.mclk_i, .sys_rst_i, .sfr_addr_i,
  .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .option_disable_i, .sfr_rdata_o, .mcu_reset_req_o,
  .watchdog_running_o);

// >>> sim/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic       mclk_i = 0;
  logic       sys_rst_i = 1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic       sfr_wr_i = 0;
  logic       sfr_rd_i = 0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic       option_disable_i = 0;
  logic [7:0] sfr_rdata_o;
  logic       mcu_reset_req_o;
  logic       watchdog_running_o;
  logic       rd_d = 0;
  logic [7:0] exp_q[$];
  logic [7:0] e;
  int         mismatches = 0;
  int         n_compared = 0;
  int         n;
  // short rc period keeps the timeout near 512 clocks at select 0
  rcw_watchdog #(.RC_CYC(2)) dut_u (.mclk_i, .sys_rst_i, .sfr_addr_i, .sfr_wr_i,
    .sfr_rd_i, .sfr_wdata_i, .option_disable_i, .sfr_rdata_o, .mcu_reset_req_o,
    .watchdog_running_o);
  initial forever #5 mclk_i = ~mclk_i;
  task automatic chk(string s, logic [7:0] x, logic [7:0] g);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1;
    @(posedge mclk_i);
    sfr_wr_i <= 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] x);
    exp_q.push_back(x);
    @(posedge mclk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1;
    @(posedge mclk_i);
    sfr_rd_i <= 0;
  endtask
  task automatic unl();
    wr(8'hF7, 8'h55);
    wr(8'hF7, 8'hAA);
    wr(8'hF7, 8'h5A);
  endtask
  task automatic rst(logic o);
    @(posedge mclk_i);
    option_disable_i <= o;
    sys_rst_i <= 1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 0;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // read data is valid in the cycle after the taking edge
  always @(negedge mclk_i) begin
    if (rd_d) chk("rdata", exp_q.pop_front(), sfr_rdata_o);
    rd_d <= sfr_rd_i;
  end
  initial begin
    void'($urandom(32'h7F49));
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 0;
    rd(8'hB6, 8'h04);
    rd(8'hB7, 8'h00);
    rd(8'hF7, 8'h00);
    wr(8'hB6, 8'hFF);
    rd(8'hB6, 8'h04);
    wr(8'hF7, 8'h55);
    wr(8'hF7, 8'h11);
    wr(8'hF7, 8'h5A);
    wr(8'hB6, 8'h03);
    rd(8'hB6, 8'h04);
    $display("test lock done");
    for (int i = 0; i < 16; i++) begin
      unl();
      wr(8'hB6, 8'(i));
      rd(8'hB6, 8'(i));
    end
    // enable bit forced on, so a wrongly taken write would show
    e = 8'($urandom) | 8'h20;
    wr(8'hB6, e);
    rd(8'hB6, 8'h0F);
    $display("test select done");
    unl();
    wr(8'hB6, 8'h20);
    unl();
    wr(8'hB6, 8'h00);
    rd(8'hB6, 8'h20);
    repeat (4) begin
      repeat (300) @(posedge mclk_i);
      wr(8'hB7, 8'h55);
    end
    wr(8'hB7, 8'h54);
    n = 0;
    while (mcu_reset_req_o !== 1'b1 && n < 2000) begin
      @(negedge mclk_i);
      n++;
    end
    chk("timeout", 8'h01, 8'(n >= 505 && n <= 520));
    @(negedge mclk_i);
    chk("running", 8'h00, {7'h00, watchdog_running_o});
    rd(8'hB6, 8'h84);
    unl();
    wr(8'hB6, 8'h04);
    rd(8'hB6, 8'h04);
    // select 2: four rc ticks per count, 256 counts, about 2048 clocks
    unl();
    wr(8'hB6, 8'h22);
    n = 0;
    while (mcu_reset_req_o !== 1'b1 && n < 4000) begin
      @(negedge mclk_i);
      n++;
    end
    chk("divided", 8'h01, 8'(n >= 2040 && n <= 2060));
    $display("test timeout done");
    rst(1'b1);
    unl();
    wr(8'hB6, 8'h20);
    @(negedge mclk_i);
    chk("option", 8'h00, {7'h00, watchdog_running_o});
    rst(1'b0);
    rd(8'hB6, 8'h04);
    $display("test option done");
    print_verdict();
  end
  initial begin
    #500000;
    mismatches++;
    print_verdict();
  end
endmodule
